// ---- src/sadc_cfg.svh ----
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
// ----------------------------------------
// widths and timing
// ----------------------------------------
`define SADC_RES_W 18
`define SADC_CNT_W 5
`define SADC_CLK_MHZ 40
`define SADC_CONV_NS 500
`define SADC_CONV_CYC ((`SADC_CONV_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_FIFO_D 8
`endif

// ---- src/sadc_pkg.sv ----
`include "sadc_cfg.svh"
package sadc_pkg;
  typedef enum logic [1:0] {SADC_IDLE, SADC_CONV, SADC_DONE} sadc_st_t;
  typedef struct packed {
    logic [`SADC_RES_W-1:0] code;
  } sadc_word_t;
endpackage : sadc_pkg

// ---- src/sadc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"
module sadc_fifo #(
  parameter int W = `SADC_RES_W,
  parameter int D = `SADC_FIFO_D
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp, rp;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  assign in_ready = (wp - rp) != (AW+1)'(D);
  assign out_valid = wp != rp;
  assign out_data = mem[rp[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end
endmodule : sadc_fifo
`default_nettype wire

// ---- src/sadc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"
module sadc_top
  import sadc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic conversion_trigger,
  input wire logic cascade_sel,
  input wire logic read_enable_or_cascade_in,
  input wire logic [`SADC_RES_W-1:0] sample_code,
  output logic busy,
  output logic sdo,
  output logic sdo_oe
);
  // ----------------------------------------
  // conversion side, clk domain
  // ----------------------------------------
  typedef struct packed {
    sadc_st_t st;
    logic [2:0] trg_sy;
    logic [7:0] cnt;
    logic busy;
    logic done_tgl;
    logic [`SADC_RES_W-1:0] hold;
    logic ack_s1;
    logic ack_s2;
    logic [1:0] csel_sy;
    logic [1:0] rd_sy;
  } sadc_cs_t;
  sadc_cs_t c, next_c;
  sadc_word_t f_out;
  logic f_in_ready, f_out_valid, take;
  logic ack_tgl;
  always_comb begin
    next_c = c;
    next_c.trg_sy = {c.trg_sy[1:0], conversion_trigger};
    next_c.ack_s1 = ack_tgl;
    next_c.ack_s2 = c.ack_s1;
    // enable follows the pins on clk, so it moves without any sclk edge
    next_c.csel_sy = {c.csel_sy[0], cascade_sel};
    next_c.rd_sy = {c.rd_sy[0], read_enable_or_cascade_in};
    take = 1'b0;
    case (c.st)
      SADC_IDLE: begin
        if (c.trg_sy[1] && !c.trg_sy[2] && f_in_ready) begin
          next_c.st = SADC_CONV;
          next_c.busy = 1'b1;
          next_c.cnt = 8'h00;
        end
      end
      SADC_CONV: begin
        next_c.cnt = c.cnt + 8'h01;
        if (c.cnt == 8'(`SADC_CONV_CYC - 1)) begin
          next_c.st = SADC_DONE;
        end
      end
      SADC_DONE: begin
        // waits on previous hand-off so the held word is never overwritten
        if (f_out_valid && (c.done_tgl == c.ack_s2)) begin
          take = 1'b1;
          next_c.hold = f_out.code;
          next_c.done_tgl = ~c.done_tgl;
          next_c.busy = 1'b0;
          next_c.st = SADC_IDLE;
        end
      end
      default: next_c.st = SADC_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end
  assign busy = c.busy;
  // the sampled input code is queued at the trigger, drained at conversion end
  sadc_fifo #(.W(`SADC_RES_W), .D(`SADC_FIFO_D)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(sample_code),
    .in_valid(c.st == SADC_IDLE && c.trg_sy[1] && !c.trg_sy[2]),
    .in_ready(f_in_ready),
    .out_data(f_out.code),
    .out_valid(f_out_valid),
    .out_ready(take)
  );
  // ----------------------------------------
  // serial side, sclk shifter, sdo/sdo_oe registered on clk
  // ----------------------------------------
  // no edges expected on sclk until busy falls; a new word is loaded by toggle
  typedef struct packed {
    logic tg_s1;
    logic tg_s2;
    logic ack;
    logic [`SADC_RES_W-1:0] sh;
    logic out;
  } sadc_ss_t;
  sadc_ss_t s, next_s;
  always_comb begin
    next_s = s;
    next_s.tg_s1 = c.done_tgl;
    next_s.tg_s2 = s.tg_s1;
    if (s.tg_s2 != s.ack) begin
      next_s.ack = s.tg_s2;
      next_s.sh = c.hold;
    end else begin
      next_s.sh = {s.sh[`SADC_RES_W-2:0], cascade_sel & read_enable_or_cascade_in};
    end
    next_s.out = next_s.sh[`SADC_RES_W-1];
  end
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign ack_tgl = s.ack;
  // MSB mux on the held word before any shift edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo <= (c.done_tgl != c.ack_s2) ? c.hold[`SADC_RES_W-1] : s.out;
      sdo_oe <= c.csel_sy[1] | ~c.rd_sy[1];
    end
  end
endmodule : sadc_top
`default_nettype wire

// ---- bench/sadc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module sadc_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic conversion_trigger,
  input wire logic cascade_sel,
  input wire logic read_enable_or_cascade_in,
  input wire logic busy,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_trig_busy: assert property (
    $rose(conversion_trigger) && !busy |-> ##[1:6] busy) else $error("busy late");
  a_busy_min: assert property (
    $rose(busy) |-> busy [*8]) else $error("busy short");
  a_busy_end: assert property (
    $rose(busy) |-> ##[19:40] !busy) else $error("busy long");
  a_busy_gap: assert property (
    $fell(busy) |=> !busy [*4]) else $error("retrigger");
  a_rd_off: assert property (
    (!cascade_sel && read_enable_or_cascade_in) [*4] |-> !sdo_oe) else $error("oe high");
  a_rd_on: assert property (
    (!cascade_sel && !read_enable_or_cascade_in) [*4] |-> sdo_oe) else $error("oe low");
  a_chain_on: assert property (
    cascade_sel [*4] |-> sdo_oe) else $error("chain oe");
  a_sdo_hold: assert property (
    (busy && $stable(sclk)) [*3] |-> $stable(sdo)) else $error("sdo moved");
  cover property ($fell(busy));
  cover property (cascade_sel && $rose(sclk));
  cover property ($rose(conversion_trigger) && busy);
endmodule : sadc_monitor
bind sadc_top sadc_monitor i_mon (.*);
`default_nettype wire

// ---- bench/sadc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
  input wire logic sdo,
  input wire logic [17:0] up,
  output logic sclk,
  output logic sdi
);
  logic [35:0] got;
  initial {sclk, sdi} = 2'b00;
  // ----
  // one edge per pulse, sclk idles low
  // ----
  task automatic pulse(input int i);
    sdi = (i >= 0 && i < 18) ? up[17 - i] : ~sdi;
    #8 got = {got[34:0], sdo};
    sclk = 1'b1;
    #16 sclk = 1'b0;
    #8;
  endtask : pulse
  task automatic frame(input int n);
    for (int i = -3; i < n; i++) begin
      pulse(i);
      // load edges done; let the device's load handshake settle first
      if (i == -1) #100;
    end
  endtask : frame
endmodule : sadc_host
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, arst_n, trig, csel, re_n, sclk, sdi, busy, sdo, sdo_oe;
  logic [17:0] code, up;
  int miscompares, compares, cyc;
  sadc_top i_dut(.clk(clk), .arst_n(arst_n), .sclk(sclk), .conversion_trigger(trig), .cascade_sel(csel),
    .read_enable_or_cascade_in(csel ? sdi : re_n), .sample_code(code), .busy(busy), .sdo(sdo), .sdo_oe(sdo_oe));
  sadc_host i_host(.sdo(sdo), .up(up), .sclk(sclk), .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (++cyc > 20000) begin
    miscompares++;
    complete_run();
  end
  // ----
  // checks and scenarios
  // ----
  task automatic check(input logic [35:0] s, input logic [35:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: %h", $time, s);
    end
  endtask : check
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // second trigger lands mid-conversion and must be ignored
  task automatic conv(input logic [17:0] c);
    @(posedge clk) {code, trig} <= {c, 1'b1};
    repeat (8) @(posedge clk);
    #1 check(busy, 1);
    @(posedge clk) trig <= 1'b0;
    @(posedge clk) trig <= 1'b1;
    #1 for (int i = 0; i < 60 && busy; i++) @(posedge clk) #1;
    repeat (2) @(posedge clk);
    #1 check({busy, sdo}, {1'b0, c[17]});
    repeat (9) @(posedge clk);
    trig <= 1'b0;
    #1 check(busy, 0);
  endtask : conv
  initial begin
    {arst_n, trig, csel, re_n, code, up} = '0;
    fork
      repeat (2) i_host.pulse(-1);
    join_none
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    up <= 18'h2d5a3;
    conv(18'h20001);
    i_host.frame(18);
    check(i_host.got[17:0], 18'h20001);
    @(posedge clk) re_n <= 1'b1;
    repeat (4) @(posedge clk);
    csel <= 1'b1;
    conv(18'h1fffe);
    i_host.frame(36);
    check(i_host.got, {18'h1fffe, 18'h2d5a3});
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
